// ### hw/ddc_defines.vh
`ifndef DDC_DEFINES_VH
`define DDC_DEFINES_VH

// Register indices; the byte address is four times the index.
`define DDC_IDX_FRAME_CLOCK_GENERATION 6'h09
`define DDC_IDX_DAC_CONTROL            6'h0a
`define DDC_IDX_LEFT_DAC_VOLUME        6'h0b
`define DDC_IDX_RIGHT_DAC_VOLUME       6'h0c
`define DDC_IDX_CONFIG                 6'h20
`define DDC_IDX_STATUS                 6'h21

// Reset values.
`define DDC_RST_FRAME_CLOCK_GENERATION 16'h0040
`define DDC_RST_DAC_CONTROL            16'h0004
`define DDC_RST_DAC_VOLUME             8'hc0
`define DDC_RST_CONFIG                 16'h0000

// Writable bits.
`define DDC_MASK_FRAME_CLOCK_GENERATION 16'h2fff
`define DDC_MASK_DAC_CONTROL            16'h23f7
`define DDC_MASK_CONFIG                 16'h0003

// Frame clock generation fields.
`define DDC_BIT_PORT_TRISTATE 13
`define DDC_BIT_FRAME_DIR     11
`define DDC_FRAME_RATE_MSB    10

// DAC control fields.
`define DDC_BIT_HIGH_OVERSAMPLE 13
`define DDC_BIT_MONO_MIX        9
`define DDC_BIT_STOPBAND_FILTER 8
`define DDC_BIT_MUTE_RAMP_RATE  7
`define DDC_BIT_UNMUTE_RAMP     6
`define DDC_DEEMPHASIS_SEL_MSB          5
`define DDC_DEEMPHASIS_SEL_LSB          4
`define DDC_BIT_SOFT_MUTE       2
`define DDC_BIT_LEFT_INVERT     1
`define DDC_BIT_RIGHT_INVERT    0

// Volume register fields.
`define DDC_BIT_VOLUME_UPDATE 8
`define DDC_VOLUME_MSB        7

// Own configuration fields.
`define DDC_BIT_AUTO_CLOCKING 0
`define DDC_BIT_MASTER_MODE   1

// Soft mute ramp: frame periods per volume step.
`define DDC_RAMP_DIV_FAST 6'h02
`define DDC_RAMP_DIV_SLOW 6'h20

// AXI responses.
`define DDC_RESP_OKAY   2'b00
`define DDC_RESP_SLVERR 2'b10

`endif

// ### hw/ddc_frame_div.v
`include "ddc_defines.vh"

module ddc_frame_div
(
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// Bit clock rising-edge enable and divisor
	input  wire        bclk_rise,
	input  wire [10:0] rate,
	// Generated frame clock
	output reg         frame_clk_reg
);

	reg  [10:0] cnt_reg;
	wire [10:0] last;
	wire        wrap;
	wire [10:0] cnt_next;
	wire        frame_clk_next;

	assign last = rate - 11'h001;
	assign wrap = (cnt_reg >= last);
	assign cnt_next = wrap ? 11'h000 : cnt_reg + 11'h001;
	// High for the first half of each frame, so odd divisors run long low.
	assign frame_clk_next = (cnt_next < {1'b0, rate[10:1]});

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_reg       <= 11'h000;
			frame_clk_reg <= 1'b0;
		end
		else if (rate == 11'h000)
		begin
			cnt_reg       <= 11'h000;
			frame_clk_reg <= 1'b0;
		end
		else if (bclk_rise)
		begin
			cnt_reg       <= cnt_next;
			frame_clk_reg <= frame_clk_next;
		end
	end

endmodule

// ### hw/ddc_top.v
// What this block does
// - Port tristate bit set puts every serial audio pin in high impedance.
// - Frame direction bit set drives the frame clock out even in slave mode.
// - Output frame clock is bit clock divided by the 11-bit rate field.
// - High oversample bit under automatic clocking selects 128fs, else 64fs.
// - Mono mix bit mixes both channels; software sets it with one disabled.
// - Stopband filter bit selects sloping filter; ignored under auto clocking.
// - Mute ramp rate 0 steps the soft mute ramp at fs/2.
// - Mute ramp rate 1 steps the soft mute ramp at fs/32.
// - Unmute ramp bit 0: volume jumps to programmed values on unmute.
// - Unmute ramp bit 1: volume rises gradually to programmed values.
// - Two-bit de-emphasis field selects off, 32k, 44.1k or 48k curve.
// - Soft mute bit mutes when 1, resets to 1.
// - Left and right invert bits negate that channel's output data.
// - Writing 1 to volume update applies both pending volumes together.
// - Left volume is 8 bits, 00h mute, C0h 0 dB and reset value.
// - Right volume register has same encoding and its own update bit.
`include "ddc_defines.vh"

module ddc_top
#(
	parameter SAMPLE_W = 16
)
(
	// Clock and reset
	input  wire                aclk,
	input  wire                aresetn,
	// AXI4-Lite write address
	input  wire [7:0]          s_axi_awaddr,
	input  wire                s_axi_awvalid,
	output wire                s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]         s_axi_wdata,
	input  wire [3:0]          s_axi_wstrb,
	input  wire                s_axi_wvalid,
	output wire                s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]          s_axi_bresp,
	output reg                 s_axi_bvalid,
	input  wire                s_axi_bready,
	// AXI4-Lite read address
	input  wire [7:0]          s_axi_araddr,
	input  wire                s_axi_arvalid,
	output wire                s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0]         s_axi_rdata,
	output reg  [1:0]          s_axi_rresp,
	output reg                 s_axi_rvalid,
	input  wire                s_axi_rready,
	// Serial audio port pins
	input  wire                tree_bclk,
	input  wire                bclk_pin_in,
	output wire                bclk_pin_out,
	output wire                bclk_pin_oe,
	input  wire                frame_pin_in,
	output wire                frame_pin_out,
	output wire                frame_pin_oe,
	// Sample stream into the DAC path
	input  wire [SAMPLE_W-1:0] sample_left,
	input  wire [SAMPLE_W-1:0] sample_right,
	input  wire                sample_valid,
	// Sample stream towards the converters
	output reg  [SAMPLE_W-1:0] dac_left_data,
	output reg  [SAMPLE_W-1:0] dac_right_data,
	output reg                 dac_data_valid,
	output reg  [7:0]          dac_left_gain,
	output reg  [7:0]          dac_right_gain,
	// Converter configuration
	output wire                dac_high_oversample,
	output wire                dac_stopband_filter_sel,
	output wire [1:0]          deemphasis_sel,
	output wire                mono_mix
);

	reg  [15:0] frame_gen_reg;
	reg  [15:0] dac_ctrl_reg;
	reg  [15:0] config_reg;
	reg  [7:0]  left_dac_volume_reg;
	reg  [7:0]  right_dac_volume_reg;
	reg  [7:0]  left_active_reg;
	reg  [7:0]  right_active_reg;
	reg  [7:0]  left_applied_reg;
	reg  [7:0]  right_applied_reg;

	wire port_tristate = frame_gen_reg[`DDC_BIT_PORT_TRISTATE];
	wire frame_dir     = frame_gen_reg[`DDC_BIT_FRAME_DIR];
	wire auto_clocking = config_reg[`DDC_BIT_AUTO_CLOCKING];
	wire master_mode   = config_reg[`DDC_BIT_MASTER_MODE];
	wire soft_mute     = dac_ctrl_reg[`DDC_BIT_SOFT_MUTE];
	wire unmute_ramp   = dac_ctrl_reg[`DDC_BIT_UNMUTE_RAMP];
	wire mute_ramp_rate = dac_ctrl_reg[`DDC_BIT_MUTE_RAMP_RATE];

	// Converter configuration.
	assign dac_high_oversample =
		dac_ctrl_reg[`DDC_BIT_HIGH_OVERSAMPLE] & auto_clocking;
	assign dac_stopband_filter_sel =
		dac_ctrl_reg[`DDC_BIT_STOPBAND_FILTER] & ~auto_clocking;
	assign deemphasis_sel =
		dac_ctrl_reg[`DDC_DEEMPHASIS_SEL_MSB:`DDC_DEEMPHASIS_SEL_LSB];
	assign mono_mix = dac_ctrl_reg[`DDC_BIT_MONO_MIX];

	// Pin synchronisers; the third stage only feeds edge detection.
	reg [2:0] tree_bclk_sync_reg;
	reg [2:0] bclk_pin_sync_reg;
	reg [1:0] frame_pin_sync_reg;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tree_bclk_sync_reg <= 3'h0;
			bclk_pin_sync_reg  <= 3'h0;
			frame_pin_sync_reg <= 2'h0;
		end
		else
		begin
			tree_bclk_sync_reg <= {tree_bclk_sync_reg[1:0], tree_bclk};
			bclk_pin_sync_reg  <= {bclk_pin_sync_reg[1:0], bclk_pin_in};
			frame_pin_sync_reg <= {frame_pin_sync_reg[0], frame_pin_in};
		end
	end

	// In master mode the device forwards the clock-tree bit clock and
	// counts it; in slave mode it counts the bit clock on the pin.
	wire bclk_rise = master_mode ?
		(tree_bclk_sync_reg[1] & ~tree_bclk_sync_reg[2]) :
		(bclk_pin_sync_reg[1] & ~bclk_pin_sync_reg[2]);

	wire frame_clk_gen;

	ddc_frame_div u_frame_div
	(
		.aclk          (aclk),
		.aresetn       (aresetn),
		.bclk_rise     (bclk_rise),
		.rate          (frame_gen_reg[`DDC_FRAME_RATE_MSB:0]),
		.frame_clk_reg (frame_clk_gen)
	);

	// Pin drive.
	wire frame_drive = master_mode | frame_dir;

	assign bclk_pin_out  = tree_bclk_sync_reg[1];
	assign bclk_pin_oe   = master_mode & ~port_tristate;
	assign frame_pin_out = frame_clk_gen;
	assign frame_pin_oe  = frame_drive & ~port_tristate;

	// Sample rate tick from the frame clock in use.
	reg  frame_prev_reg;
	wire frame_now = frame_drive ? frame_clk_gen : frame_pin_sync_reg[1];
	wire fs_tick   = frame_now & ~frame_prev_reg;

	// Ramp prescaler; one volume step per 2 or 32 frames.
	reg  [4:0] ramp_cnt_reg;
	// The divisor needs six bits to hold 32; the counter wraps to 0 after 31 at the slow rate, after 1 at the fast rate.
	wire [5:0] ramp_div = mute_ramp_rate ?
		`DDC_RAMP_DIV_SLOW : `DDC_RAMP_DIV_FAST;
	wire       ramp_wrap = ({1'b0, ramp_cnt_reg} >= ramp_div - 6'h01);
	wire       ramp_step = fs_tick & ramp_wrap;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			frame_prev_reg <= 1'b0;
			ramp_cnt_reg   <= 5'h00;
		end
		else
		begin
			frame_prev_reg <= frame_now;
			if (fs_tick)
				ramp_cnt_reg <= ramp_wrap ? 5'h00 : ramp_cnt_reg + 5'h01;
		end
	end

	// Applied volume, one step per ramp step while muting or ramping up, else jumps to the target.
	wire [15:0] applied_pair;
	wire [15:0] next_pair;
	wire [15:0] active_pair = {right_active_reg, left_active_reg};
	wire [1:0]  ramp_busy;

	assign applied_pair = {right_applied_reg, left_applied_reg};

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1)
		begin : g_vol
			wire [7:0] cur = applied_pair[ch*8+7:ch*8];
			wire [7:0] tgt = active_pair[ch*8+7:ch*8];
			reg  [7:0] nxt;

			always @*
			begin
				nxt = cur;
				if (soft_mute)
				begin
					if (ramp_step && cur != 8'h00)
						nxt = cur - 8'h01;
				end
				else if (unmute_ramp && cur < tgt)
				begin
					if (ramp_step)
						nxt = cur + 8'h01;
				end
				else
					nxt = tgt;
			end

			assign next_pair[ch*8+7:ch*8] = nxt;
			assign ramp_busy[ch] = soft_mute ? (cur != 8'h00) : (cur != tgt);
		end
	endgenerate

	// Data path: mono mix, then inversion with saturation.
	wire signed [SAMPLE_W:0] mix_sum =
		$signed({sample_left[SAMPLE_W-1], sample_left}) +
		$signed({sample_right[SAMPLE_W-1], sample_right});
	wire [SAMPLE_W-1:0] mix_half = mix_sum[SAMPLE_W:1];
	wire [SAMPLE_W-1:0] src_left  = mono_mix ? mix_half : sample_left;
	wire [SAMPLE_W-1:0] src_right = mono_mix ? mix_half : sample_right;

	function [SAMPLE_W-1:0] ddc_negate;
		input [SAMPLE_W-1:0] v;
		reg   [SAMPLE_W-1:0] most_neg;
		begin
			most_neg = {1'b1, {(SAMPLE_W-1){1'b0}}};
			// Full-scale negative has no positive twin; clamp it.
			if (v == most_neg)
				ddc_negate = ~most_neg;
			else
				ddc_negate = ~v + {{(SAMPLE_W-1){1'b0}}, 1'b1};
		end
	endfunction

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dac_left_data  <= {SAMPLE_W{1'b0}};
			dac_right_data <= {SAMPLE_W{1'b0}};
			dac_data_valid <= 1'b0;
			dac_left_gain  <= 8'h00;
			dac_right_gain <= 8'h00;
		end
		else
		begin
			dac_data_valid <= sample_valid;
			dac_left_gain  <= left_applied_reg;
			dac_right_gain <= right_applied_reg;
			if (sample_valid)
			begin
				dac_left_data <= dac_ctrl_reg[`DDC_BIT_LEFT_INVERT] ?
					ddc_negate(src_left) : src_left;
				dac_right_data <= dac_ctrl_reg[`DDC_BIT_RIGHT_INVERT] ?
					ddc_negate(src_right) : src_right;
			end
		end
	end

	// AXI4-Lite write side: address and data are held until both are in.
	reg        aw_full_reg;
	reg        w_full_reg;
	reg [5:0]  aw_idx_reg;
	reg [15:0] w_data_reg;
	reg [1:0]  w_strb_reg;

	assign s_axi_awready = ~aw_full_reg;
	assign s_axi_wready  = ~w_full_reg;

	wire do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
	wire [15:0] strb_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

	function [15:0] ddc_merge;
		input [15:0] old;
		input [15:0] data;
		input [15:0] wmask;
		begin
			ddc_merge = (old & ~wmask) | (data & wmask);
		end
	endfunction

	wire wr_frame = do_write &&
		aw_idx_reg == `DDC_IDX_FRAME_CLOCK_GENERATION;
	wire wr_ctrl  = do_write && aw_idx_reg == `DDC_IDX_DAC_CONTROL;
	wire wr_left  = do_write && aw_idx_reg == `DDC_IDX_LEFT_DAC_VOLUME;
	wire wr_right = do_write && aw_idx_reg == `DDC_IDX_RIGHT_DAC_VOLUME;
	wire wr_cfg   = do_write && aw_idx_reg == `DDC_IDX_CONFIG;
	wire wr_known = wr_frame | wr_ctrl | wr_left | wr_right | wr_cfg |
		(aw_idx_reg == `DDC_IDX_STATUS);

	wire [7:0] left_next = w_strb_reg[0] ?
		w_data_reg[`DDC_VOLUME_MSB:0] : left_dac_volume_reg;
	wire [7:0] right_next = w_strb_reg[0] ?
		w_data_reg[`DDC_VOLUME_MSB:0] : right_dac_volume_reg;
	wire vol_update = (wr_left | wr_right) & w_strb_reg[1] &
		w_data_reg[`DDC_BIT_VOLUME_UPDATE];

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_reg          <= 1'b0;
			w_full_reg           <= 1'b0;
			aw_idx_reg           <= 6'h00;
			w_data_reg           <= 16'h0000;
			w_strb_reg           <= 2'h0;
			s_axi_bvalid         <= 1'b0;
			s_axi_bresp          <= `DDC_RESP_OKAY;
			frame_gen_reg        <= `DDC_RST_FRAME_CLOCK_GENERATION;
			dac_ctrl_reg         <= `DDC_RST_DAC_CONTROL;
			config_reg           <= `DDC_RST_CONFIG;
			left_dac_volume_reg  <= `DDC_RST_DAC_VOLUME;
			right_dac_volume_reg <= `DDC_RST_DAC_VOLUME;
			left_active_reg      <= `DDC_RST_DAC_VOLUME;
			right_active_reg     <= `DDC_RST_DAC_VOLUME;
			left_applied_reg     <= 8'h00;
			right_applied_reg    <= 8'h00;
		end
		else
		begin
			if (s_axi_awvalid && !aw_full_reg)
			begin
				aw_full_reg <= 1'b1;
				aw_idx_reg  <= s_axi_awaddr[7:2];
			end
			if (s_axi_wvalid && !w_full_reg)
			begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata[15:0];
				w_strb_reg <= s_axi_wstrb[1:0];
			end
			if (do_write)
			begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? `DDC_RESP_OKAY : `DDC_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_frame)
				frame_gen_reg <= ddc_merge(frame_gen_reg, w_data_reg,
					strb_mask & `DDC_MASK_FRAME_CLOCK_GENERATION);
			if (wr_ctrl)
				dac_ctrl_reg <= ddc_merge(dac_ctrl_reg, w_data_reg,
					strb_mask & `DDC_MASK_DAC_CONTROL);
			if (wr_cfg)
				config_reg <= ddc_merge(config_reg, w_data_reg,
					strb_mask & `DDC_MASK_CONFIG);
			if (wr_left)
				left_dac_volume_reg <= left_next;
			if (wr_right)
				right_dac_volume_reg <= right_next;
			// Both channels move together, taking this write's byte too.
			if (vol_update)
			begin
				left_active_reg  <= wr_left ? left_next : left_dac_volume_reg;
				right_active_reg <= wr_right ? right_next :
					right_dac_volume_reg;
			end
			left_applied_reg  <= next_pair[7:0];
			right_applied_reg <= next_pair[15:8];
		end
	end

	// AXI4-Lite read side.
	assign s_axi_arready = ~s_axi_rvalid;

	reg [31:0] rd_word;
	reg        rd_known;

	always @*
	begin
		rd_word  = 32'h0000_0000;
		rd_known = 1'b1;
		case (s_axi_araddr[7:2])
			`DDC_IDX_FRAME_CLOCK_GENERATION: rd_word[15:0] = frame_gen_reg;
			`DDC_IDX_DAC_CONTROL:            rd_word[15:0] = dac_ctrl_reg;
			`DDC_IDX_LEFT_DAC_VOLUME:        rd_word[7:0]  = left_dac_volume_reg;
			`DDC_IDX_RIGHT_DAC_VOLUME:       rd_word[7:0]  = right_dac_volume_reg;
			`DDC_IDX_CONFIG:                 rd_word[15:0] = config_reg;
			`DDC_IDX_STATUS:
				rd_word[19:0] = {port_tristate, frame_now, ramp_busy,
					right_applied_reg, left_applied_reg};
			default:                         rd_known = 1'b0;
		endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `DDC_RESP_OKAY;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_known ? `DDC_RESP_OKAY : `DDC_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule

// ### verification/dac_digital_control_test.sv
module dac_digital_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 0, aresetn = 0, sv = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [15:0] sl = 0, sr = 0;
	wire  [31:0] rdata;
	wire  [15:0] dl, dr;
	wire  [7:0]  gl, gr;
	wire  [1:0]  bresp, rresp, de;
	wire         awready, wready, bvalid, arready, rvalid, dv, hi, sb, mm;
	wire         tbc, bpi, bpo, bpoe, fpi, fpo, fpoe;
	int          err_count = 0, compares = 0, g, i;
	logic [7:0]  d;

	ddc_top u_ddc_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .tree_bclk(tbc),
		.bclk_pin_in(bpi), .bclk_pin_out(bpo), .bclk_pin_oe(bpoe),
		.frame_pin_in(fpi), .frame_pin_out(fpo), .frame_pin_oe(fpoe),
		.sample_left(sl), .sample_right(sr), .sample_valid(sv),
		.dac_left_data(dl), .dac_right_data(dr), .dac_data_valid(dv),
		.dac_left_gain(gl), .dac_right_gain(gr), .dac_high_oversample(hi),
		.dac_stopband_filter_sel(sb), .deemphasis_sel(de), .mono_mix(mm));
	ddc_audio_host u_ddc_audio_host (.aclk(aclk), .aresetn(aresetn),
		.bclk_pin_out(bpo), .bclk_pin_oe(bpoe), .frame_pin_out(fpo),
		.frame_pin_oe(fpoe), .tree_bclk(tbc), .bclk_pin_in(bpi),
		.frame_pin_in(fpi));

	initial
		forever #4 aclk = ~aclk;

	task end_of_test;
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task timed_out;
		err_count++;
		end_of_test;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask

	// Handshakes are sampled at the falling edge, where nothing moves.
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] r;
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 0;
			if (tw) wvalid <= 0;
			if (tb) break;
		end
		bready <= 0;
		if (n == 50) timed_out;
		else chk(r, er);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
		logic ta, tr;
		logic [31:0] v;
		logic [1:0] r;
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			v = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 0;
			if (tr) break;
		end
		rready <= 0;
		if (n == 50) timed_out;
		else
		begin
			chk(v, ev);
			chk(r, er);
		end
	endtask

	task smp(input logic [15:0] l, r, el, er);
		@(posedge aclk);
		sl <= l;
		sr <= r;
		sv <= 1;
		@(posedge aclk);
		sv <= 0;
		@(negedge aclk);
		chk(dv, 1);
		chk(dl, el);
		chk(dr, er);
	endtask

	// Cycles between two changes of the frame pin or of the left gain.
	function logic [7:0] val(input logic f);
		return f ? {7'h00, fpo} : gl;
	endfunction

	task gap(input logic f);
		logic [7:0] v0;
		int n;
		v0 = val(f);
		for (n = 0; n < 3000 && val(f) === v0; n++)
			@(negedge aclk);
		v0 = val(f);
		for (g = 0; g < 3000 && val(f) === v0; g++)
			@(negedge aclk);
		d = val(f) - v0;
		if (n == 3000 || g == 3000) timed_out;
	endtask

	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		rd(8'h24, 32'h0000_0040, 2'b00);
		rd(8'h28, 32'h0000_0004, 2'b00);
		rd(8'h2c, 32'h0000_00c0, 2'b00);
		rd(8'h30, 32'h0000_00c0, 2'b00);
		rd(8'h40, 32'h0000_0000, 2'b10);
		rd(8'h84, 32'h0000_0000, 2'b00);
		wr(8'h84, 32'h0000_ffff, 2'b00);
		rd(8'h84, 32'h0000_0000, 2'b00);
		wr(8'h44, 32'h0000_ffff, 2'b10);
		wr(8'h80, 32'h0000_0002, 2'b00);
		wr(8'h24, 32'h0000_2006, 2'b00);
		tick(2);
		chk({bpoe, fpoe}, 2'b00);
		wr(8'h24, 32'h0000_0006, 2'b00);
		tick(2);
		chk({bpoe, fpoe}, 2'b11);
		wr(8'h80, 32'h0000_0000, 2'b00);
		wr(8'h24, 32'h0000_0806, 2'b00);
		tick(2);
		chk({bpoe, fpoe}, 2'b01);
		wr(8'h80, 32'h0000_0002, 2'b00);
		gap(1);
		chk(g, 24);
		chk(gl, 8'h00);
		wr(8'h28, 32'h0000_0000, 2'b00);
		tick(4);
		chk({gl, gr}, 16'hc0c0);
		wr(8'h28, 32'h0000_0004, 2'b00);
		gap(0);
		chk(g, 96);
		chk(d, 8'hff);
		wr(8'h28, 32'h0000_0084, 2'b00);
		gap(0);
		chk(g, 1536);
		wr(8'h28, 32'h0000_0040, 2'b00);
		gap(0);
		chk(g, 96);
		chk(d, 8'h01);
		wr(8'h28, 32'h0000_0000, 2'b00);
		wr(8'h2c, 32'h0000_0010, 2'b00);
		tick(4);
		chk(gl, 8'hc0);
		wr(8'h30, 32'h0000_0120, 2'b00);
		tick(4);
		chk({gl, gr}, 16'h1020);
		rd(8'h2c, 32'h0000_0010, 2'b00);
		wr(8'h28, 32'h0000_0003, 2'b00);
		smp(16'h0100, 16'h8000, 16'hff00, 16'h7fff);
		wr(8'h28, 32'h0000_0200, 2'b00);
		tick(1);
		chk(mm, 1);
		smp(16'h0100, 16'h0300, 16'h0200, 16'h0200);
		for (i = 0; i < 4; i++)
		begin
			wr(8'h28, i << 4, 2'b00);
			tick(1);
			chk(de, i[1:0]);
		end
		wr(8'h80, 32'h0000_0003, 2'b00);
		wr(8'h28, 32'h0000_2100, 2'b00);
		tick(1);
		chk({hi, sb}, 2'b10);
		wr(8'h80, 32'h0000_0002, 2'b00);
		tick(1);
		chk({hi, sb}, 2'b01);
		end_of_test;
	end
endmodule

// ### verification/ddc_audio_host.sv
module ddc_audio_host
(
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Pins as driven by the device
	input  wire logic bclk_pin_out,
	input  wire logic bclk_pin_oe,
	input  wire logic frame_pin_out,
	input  wire logic frame_pin_oe,
	// Clock tree and wire levels
	output wire logic tree_bclk,
	output wire logic bclk_pin_in,
	output wire logic frame_pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] cnt_reg = 9'h000;
	// Bit clock is aclk/8 so the device synchroniser sees every edge.
	always @(posedge aclk)
		cnt_reg <= aresetn ? cnt_reg + 9'h001 : 9'h000;
	assign tree_bclk = cnt_reg[2];
	// The host drives each shared wire whenever the device lets go of it.
	assign bclk_pin_in = bclk_pin_oe ? bclk_pin_out : cnt_reg[2];
	assign frame_pin_in = frame_pin_oe ? frame_pin_out : cnt_reg[8];
endmodule

// ### verification/ddc_top_asserts.sv
module ddc_top_asserts
(
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Audio side
	input wire logic        bclk_pin_oe,
	input wire logic        frame_pin_oe,
	input wire logic        sample_valid,
	input wire logic        dac_data_valid,
	input wire logic [7:0]  dac_left_gain,
	input wire logic [7:0]  dac_right_gain,
	input wire logic        dac_high_oversample,
	input wire logic        dac_stopband_filter_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped or changed");
	a_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped or changed");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:20] == 0)
		else $error("read data upper bits set");
	a_sample_out: assert property (
		sample_valid |=> dac_data_valid)
		else $error("sample not passed on");
	a_oe_order: assert property (bclk_pin_oe |-> frame_pin_oe)
		else $error("bit clock driven without frame clock");
	a_reset_muted: assert property (
		$rose(aresetn) |-> dac_left_gain == 0 && dac_right_gain == 0)
		else $error("gain not muted after reset");
	a_clock_mode: assert property (
		!(dac_high_oversample && dac_stopband_filter_sel))
		else $error("oversample and stopband both set");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_ramp: cover property (dac_left_gain != $past(dac_left_gain));
endmodule

bind ddc_top ddc_top_asserts u_ddc_top_asserts (.*);
